// *** reset_strap_defs.svh ***
/*
  Constants of the reset sequencer: release delays, reference and auxiliary
  clock rates, register offsets, field positions and reset values.
  Assumes it is included by bare name wherever a constant is needed.
*/
`ifndef RESET_STRAP_DEFS_SVH
`define RESET_STRAP_DEFS_SVH

// ---------------------------------------------------------------------------
// release delays, in reference clock ticks
// ---------------------------------------------------------------------------
`define POWER_RELEASE_TICKS 16000
`define EXT_RELEASE_TICKS   14'h0010
`define RELEASE_CNT_W       14

// ---------------------------------------------------------------------------
// clock rates, in kHz
// ---------------------------------------------------------------------------
`define REF_CLOCK_KHZ  10000
`define AUX_SLOW_KHZ   4000
`define AUX_MID_KHZ    10000
`define AUX_FAST_KHZ   40000
`define AUX_DIV_W      8

// ---------------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------------
`define ADDR_W           8
`define REG_PAD_CTRL     8'h00
`define REG_STATUS       8'h04
`define PAD_PULL_LSB     0
`define PAD_PULL_W       4
`define PAD_WEAK_LSB     8
`define PAD_WEAK_W       4
`define PAD_PULL_RESET   4'h0
`define PAD_WEAK_RESET   4'h0
`define ST_STATE_LSB     0
`define ST_AUX_LSB       8
`define ST_HOST_LSB      12
`define ST_CLK_STRAP_LSB 16
`define ST_IF_STRAP_LSB  18
`define ST_POWER_SEEN    20
`define ST_EXT_SEEN      21
`define ST_TEST_BAD      22
`define DATA_ZERO        32'h0000_0000

`endif

// *** reset_strap_pkg.sv ***
/*
  Types of the reset sequencer: sequencer states, auxiliary clock settings
  and host interface choices.
  Assumes nothing; it is compiled before every design file.
*/
package reset_strap_pkg;

  typedef enum logic [4:0] {
    st_power_hold = 5'h01,
    st_power_wait = 5'h02,
    st_ext_hold   = 5'h04,
    st_ext_wait   = 5'h08,
    st_run        = 5'h10
  } rst_state_t;

  typedef enum logic [3:0] {
    aux_off  = 4'h1,
    aux_slow = 4'h2,
    aux_mid  = 4'h4,
    aux_fast = 4'h8
  } aux_setting_t;

  typedef enum logic [3:0] {
    host_if_a = 4'h1,
    host_if_b = 4'h2,
    host_if_c = 4'h4,
    host_if_d = 4'h8
  } host_if_t;

endpackage

// *** level_sync.sv ***
/*
  Two-stage synchroniser for one level.
  Assumes the input may change at any time relative to core_clk; the first
  stage is read by the second stage only.
*/
module level_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // level
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      meta     <= RESET_LEVEL;
      sync_out <= RESET_LEVEL;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // level_sync

// *** reset_strap_aux_clock_out_ctrl.sv ***
/*
  Reset sequencer with strap capture and auxiliary clock output control.
  Assumes core_clk is the buffered oscillator reference, the power monitors
  drive por_active and lvr_active high while active, and software reaches
  the pad controls and status over a plain strobe port.
*/
// What this block does
// - internal reset asserts on power-on, low voltage or low reset pin.
// - reset entry is asynchronous and needs no clock edge.
// - reset release needs a running reference clock; none keeps reset.
// - power or low-voltage reset releases about 16000 ticks later.
// - power reset latches both strap pairs, auxiliary clock disabled.
// - after release the auxiliary clock is off or runs at half the reference, whatever rate is strapped.
// - after release the host interface follows the last strap value.
// - external reset releases about 16 ticks after the pin rises.
// - external reset latches straps but keeps the auxiliary clock.
// - auxiliary clock is off or one of three settings, all at half the reference.
// - pull-controlled pins leave reset with pulls disabled.
// - drive-controlled pins leave reset at full strength.
// - all clocks derive from the buffered oscillator reference.
`include "reset_strap_defs.svh"

module reset_strap_aux_clock_out_ctrl #(
  parameter int unsigned POWER_RELEASE_TICKS = `POWER_RELEASE_TICKS,
  parameter reset_strap_pkg::aux_setting_t CLK_MAP_0 =
    reset_strap_pkg::aux_off,
  parameter reset_strap_pkg::aux_setting_t CLK_MAP_1 =
    reset_strap_pkg::aux_slow,
  parameter reset_strap_pkg::aux_setting_t CLK_MAP_2 =
    reset_strap_pkg::aux_mid,
  parameter reset_strap_pkg::aux_setting_t CLK_MAP_3 =
    reset_strap_pkg::aux_fast,
  parameter reset_strap_pkg::host_if_t IF_MAP_0 = reset_strap_pkg::host_if_a,
  parameter reset_strap_pkg::host_if_t IF_MAP_1 = reset_strap_pkg::host_if_b,
  parameter reset_strap_pkg::host_if_t IF_MAP_2 = reset_strap_pkg::host_if_c,
  parameter reset_strap_pkg::host_if_t IF_MAP_3 = reset_strap_pkg::host_if_d
) (
  // buffered oscillator reference and its own power-up reset
  input  wire logic                            core_clk,
  input  wire logic                            rst_n,
  // reset sources and factory test strap
  input  wire logic                            por_active,
  input  wire logic                            lvr_active,
  input  wire logic                            ext_reset_n,
  input  wire logic                            factory_test,
  // strap pins
  input  wire logic [1:0]                      clk_strap,
  input  wire logic [1:0]                      if_strap,
  // internal reset and selections
  output logic                                 sys_reset_n,
  output reset_strap_pkg::host_if_t            host_if_sel,
  output reset_strap_pkg::aux_setting_t        aux_setting,
  // auxiliary clock pin
  output logic                                 aux_clock_out,
  output logic                                 aux_clock_oe,
  // pad controls
  output logic [`PAD_PULL_W-1:0]               pull_enable,
  output logic [`PAD_WEAK_W-1:0]               drive_weak,
  // register port
  input  wire logic [`ADDR_W-1:0]              reg_addr,
  input  wire logic [31:0]                     reg_wdata,
  input  wire logic                            reg_wr,
  input  wire logic                            reg_rd,
  output logic [31:0]                          reg_rdata
);

  // -------------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------------
  localparam logic [`RELEASE_CNT_W-1:0] POWER_LOAD =
    `RELEASE_CNT_W'(POWER_RELEASE_TICKS - 1);
  localparam logic [`RELEASE_CNT_W-1:0] EXT_LOAD =
    `EXT_RELEASE_TICKS - 14'h0001;

  // half period of the auxiliary clock in reference cycles, at least one
  function automatic logic [`AUX_DIV_W-1:0] half_period(input int khz);
    int cycles;
    cycles = `REF_CLOCK_KHZ / (2 * khz);
    if (cycles < 1) begin
      cycles = 1;
    end
    return `AUX_DIV_W'(cycles);
  endfunction

  function automatic reset_strap_pkg::aux_setting_t clk_decode(
    input logic [1:0] code);
    case (code)
      2'h0:    return CLK_MAP_0;
      2'h1:    return CLK_MAP_1;
      2'h2:    return CLK_MAP_2;
      default: return CLK_MAP_3;
    endcase
  endfunction

  function automatic reset_strap_pkg::host_if_t if_decode(
    input logic [1:0] code);
    case (code)
      2'h0:    return IF_MAP_0;
      2'h1:    return IF_MAP_1;
      2'h2:    return IF_MAP_2;
      default: return IF_MAP_3;
    endcase
  endfunction

  // -------------------------------------------------------------------------
  // reset sources
  // -------------------------------------------------------------------------
  reset_strap_pkg::rst_state_t state;
  reset_strap_pkg::rst_state_t next_state;
  logic                        ext_sync_n;
  logic                        power_src;
  logic [`RELEASE_CNT_W-1:0]   release_cnt;
  logic                        cnt_done;

  level_sync #(
    .RESET_LEVEL (1'b0)
  ) u_ext_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (ext_reset_n),
    .sync_out (ext_sync_n)
  );

  // the monitors are level outputs of analog blocks on this same clock tree
  assign power_src = por_active | lvr_active;
  assign cnt_done  = (release_cnt == '0);

  // raw pin and monitor terms reach the output without any flop, so entry
  // does not wait for an edge; only the release is clocked
  assign sys_reset_n = ~(power_src | ~ext_reset_n) &
                       (state == reset_strap_pkg::st_run);

  // -------------------------------------------------------------------------
  // release sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      reset_strap_pkg::st_power_hold: begin
        if (!power_src) begin
          next_state = reset_strap_pkg::st_power_wait;
        end
      end
      reset_strap_pkg::st_power_wait: begin
        if (power_src) begin
          next_state = reset_strap_pkg::st_power_hold;
        end else if (cnt_done && ext_sync_n) begin
          next_state = reset_strap_pkg::st_run;
        end
      end
      reset_strap_pkg::st_ext_hold: begin
        if (power_src) begin
          next_state = reset_strap_pkg::st_power_hold;
        end else if (ext_sync_n) begin
          next_state = reset_strap_pkg::st_ext_wait;
        end
      end
      reset_strap_pkg::st_ext_wait: begin
        if (power_src) begin
          next_state = reset_strap_pkg::st_power_hold;
        end else if (!ext_sync_n) begin
          next_state = reset_strap_pkg::st_ext_hold;
        end else if (cnt_done) begin
          next_state = reset_strap_pkg::st_run;
        end
      end
      reset_strap_pkg::st_run: begin
        if (power_src) begin
          next_state = reset_strap_pkg::st_power_hold;
        end else if (!ext_sync_n) begin
          next_state = reset_strap_pkg::st_ext_hold;
        end
      end
      default: next_state = reset_strap_pkg::st_power_hold;
    endcase
  end

  // without reference edges nothing here advances, so reset stays held
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= reset_strap_pkg::st_power_hold;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      release_cnt <= POWER_LOAD;
    end else if (next_state == reset_strap_pkg::st_power_hold) begin
      release_cnt <= POWER_LOAD;
    end else if (next_state == reset_strap_pkg::st_ext_hold &&
                 state != reset_strap_pkg::st_power_wait) begin
      release_cnt <= EXT_LOAD;
    end else if (!cnt_done && (state == reset_strap_pkg::st_power_wait ||
                               state == reset_strap_pkg::st_ext_wait)) begin
      release_cnt <= release_cnt - 1'b1;
    end
  end

  // -------------------------------------------------------------------------
  // strap capture and selection
  // -------------------------------------------------------------------------
  logic [1:0] clk_latched;
  logic [1:0] if_latched;
  logic       in_reset;
  logic       power_reset;
  logic       releasing;

  assign in_reset    = (state != reset_strap_pkg::st_run);
  assign power_reset = (state == reset_strap_pkg::st_power_hold) ||
                       (state == reset_strap_pkg::st_power_wait);
  assign releasing   = in_reset && (next_state == reset_strap_pkg::st_run);

  // straps are followed for the whole reset, the last value wins
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_latched <= 2'h0;
      if_latched  <= 2'h0;
    end else if (in_reset) begin
      clk_latched <= clk_strap;
      if_latched  <= if_strap;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_if_sel <= IF_MAP_0;
    end else if (releasing) begin
      host_if_sel <= if_decode(if_latched);
    end
  end

  // an external reset keeps the old setting so the clock keeps running;
  // a power source stops it at the first edge that sees the source
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      aux_setting <= reset_strap_pkg::aux_off;
    end else if (releasing) begin
      aux_setting <= clk_decode(clk_latched);
    end else if (power_reset || power_src) begin
      aux_setting <= reset_strap_pkg::aux_off;
    end
  end

  // -------------------------------------------------------------------------
  // auxiliary clock divider
  // -------------------------------------------------------------------------
  // rates above half the reference saturate at a one-cycle half period;
  // the true top rate needs a multiplied clock that this block does not have
  logic [`AUX_DIV_W-1:0] div_cnt;
  logic [`AUX_DIV_W-1:0] div_limit;
  logic                  aux_tick;

  always_comb begin
    case (aux_setting)
      reset_strap_pkg::aux_slow: div_limit = half_period(`AUX_SLOW_KHZ);
      reset_strap_pkg::aux_mid:  div_limit = half_period(`AUX_MID_KHZ);
      reset_strap_pkg::aux_fast: div_limit = half_period(`AUX_FAST_KHZ);
      default:                   div_limit = half_period(`AUX_SLOW_KHZ);
    endcase
  end

  assign aux_tick = (div_cnt >= div_limit - 1'b1);

  always_ff @(posedge core_clk) begin
    if (!rst_n || aux_setting == reset_strap_pkg::aux_off) begin
      div_cnt <= '0;
    end else if (aux_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || power_src || aux_setting == reset_strap_pkg::aux_off) begin
      aux_clock_out <= 1'b0;
      aux_clock_oe  <= 1'b0;
    end else begin
      aux_clock_oe <= 1'b1;
      if (aux_tick) begin
        aux_clock_out <= ~aux_clock_out;
      end
    end
  end

  // -------------------------------------------------------------------------
  // pad controls and status
  // -------------------------------------------------------------------------
  logic power_seen;
  logic ext_seen;
  logic test_bad;

  // pad controls return to defaults on every internal reset
  always_ff @(posedge core_clk) begin
    if (!rst_n || !sys_reset_n) begin
      pull_enable <= `PAD_PULL_RESET;
      drive_weak  <= `PAD_WEAK_RESET;
    end else if (reg_wr && reg_addr == `REG_PAD_CTRL) begin
      pull_enable <= reg_wdata[`PAD_PULL_LSB +: `PAD_PULL_W];
      drive_weak  <= reg_wdata[`PAD_WEAK_LSB +: `PAD_WEAK_W];
    end
  end

  // cause flags: a new cause in the cycle of a clear wins over the clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      power_seen <= 1'b1;
      ext_seen   <= 1'b0;
      test_bad   <= 1'b0;
    end else begin
      if (power_reset) begin
        power_seen <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS &&
                   reg_wdata[`ST_POWER_SEEN]) begin
        power_seen <= 1'b0;
      end
      if (state == reset_strap_pkg::st_ext_hold) begin
        ext_seen <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS &&
                   reg_wdata[`ST_EXT_SEEN]) begin
        ext_seen <= 1'b0;
      end
      if (factory_test) begin
        test_bad <= 1'b1;
      end else if (reg_wr && reg_addr == `REG_STATUS &&
                   reg_wdata[`ST_TEST_BAD]) begin
        test_bad <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= `DATA_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= `DATA_ZERO;
      case (reg_addr)
        `REG_PAD_CTRL: begin
          reg_rdata[`PAD_PULL_LSB +: `PAD_PULL_W] <= pull_enable;
          reg_rdata[`PAD_WEAK_LSB +: `PAD_WEAK_W] <= drive_weak;
        end
        `REG_STATUS: begin
          reg_rdata[`ST_STATE_LSB +: 5]     <= state;
          reg_rdata[`ST_AUX_LSB +: 4]       <= aux_setting;
          reg_rdata[`ST_HOST_LSB +: 4]      <= host_if_sel;
          reg_rdata[`ST_CLK_STRAP_LSB +: 2] <= clk_latched;
          reg_rdata[`ST_IF_STRAP_LSB +: 2]  <= if_latched;
          reg_rdata[`ST_POWER_SEEN]         <= power_seen;
          reg_rdata[`ST_EXT_SEEN]           <= ext_seen;
          reg_rdata[`ST_TEST_BAD]           <= test_bad;
        end
        default: reg_rdata <= `DATA_ZERO;
      endcase
    end
  end

endmodule // reset_strap_aux_clock_out_ctrl

// *** reset_strap_properties.sv ***
/*
  Checker of the reset sequencer, release timing and output selections.
  Assumes it is bound to reset_strap_aux_clock_out_ctrl and sees only its ports.
*/
`include "reset_strap_defs.svh"

module reset_strap_checker #(
  parameter int unsigned POWER_RELEASE_TICKS = 20
) (
  // clock and reset
  input wire logic                          core_clk,
  input wire logic                          rst_n,
  // sources
  input wire logic                          por_active,
  input wire logic                          lvr_active,
  input wire logic                          ext_reset_n,
  // outputs watched
  input wire logic                          sys_reset_n,
  input wire reset_strap_pkg::host_if_t     host_if_sel,
  input wire reset_strap_pkg::aux_setting_t aux_setting,
  input wire logic                          aux_clock_out,
  input wire logic                          aux_clock_oe,
  input wire logic [`PAD_PULL_W-1:0]        pull_enable,
  input wire logic [`PAD_WEAK_W-1:0]        drive_weak
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------
  // cycles since a power source was last seen; saturates to stay small
  // --------------------------------------------------------------------
  int unsigned quiet_cnt;

  always_ff @(posedge core_clk) begin
    if (!rst_n || por_active || lvr_active) begin
      quiet_cnt <= 0;
    end else if (quiet_cnt < 100000) begin
      quiet_cnt <= quiet_cnt + 1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence held_low;
    !sys_reset_n [*8];
  endsequence
  sequence comes_out;
    ##[8:14] sys_reset_n;
  endsequence

  a_source_forces_reset: assert property (
    (por_active || lvr_active || !ext_reset_n) |-> !sys_reset_n)
    else $error("internal reset high while a source is active");
  a_power_release_late: assert property ($rose(sys_reset_n) |->
    quiet_cnt >= POWER_RELEASE_TICKS + 1)
    else $error("internal reset released too early after power source");
  a_ext_release_time: assert property (($rose(ext_reset_n) &&
    quiet_cnt > POWER_RELEASE_TICKS + 4) |-> held_low ##0 comes_out)
    else $error("external reset release outside its window");
  a_power_aux_off: assert property ((por_active || lvr_active) |=>
    (aux_setting == reset_strap_pkg::aux_off) && !aux_clock_oe)
    else $error("aux clock not disabled in power reset");
  a_sel_frozen_run: assert property (
    (sys_reset_n && $past(sys_reset_n)) |->
    $stable(host_if_sel) && $stable(aux_setting))
    else $error("selection changed while running");
  a_oe_follows_setting: assert property (
    (aux_setting != reset_strap_pkg::aux_off) |-> ##[0:1] aux_clock_oe)
    else $error("aux clock enable missing for an active setting");
  a_oe_off_quiet: assert property (
    (aux_setting == reset_strap_pkg::aux_off) [*2] |-> !aux_clock_oe)
    else $error("aux clock enabled while setting is off");
  a_aux_toggles: assert property (aux_clock_oe [*3] |->
    aux_clock_out != $past(aux_clock_out))
    else $error("aux clock did not toggle");
  a_pads_default: assert property (
    (!sys_reset_n ##1 !sys_reset_n) |->
    pull_enable == '0 && drive_weak == '0)
    else $error("pad controls not at defaults in reset");
endmodule // reset_strap_checker

bind reset_strap_aux_clock_out_ctrl reset_strap_checker #(
  .POWER_RELEASE_TICKS(POWER_RELEASE_TICKS)
) u_checker (.core_clk, .rst_n, .por_active, .lvr_active, .ext_reset_n,
  .sys_reset_n, .host_if_sel, .aux_setting, .aux_clock_out, .aux_clock_oe,
  .pull_enable, .drive_weak);

// *** board_model.sv ***
/*
  Board side: factory test strap and a consumer of the auxiliary clock.
  Assumes aux_clock_out changes only on rising core_clk edges.
*/
module board_model (
  // clock
  input  wire logic core_clk,
  // auxiliary clock pin
  input  wire logic aux_clock_out,
  input  wire logic aux_clock_oe,
  // board straps and observations
  output logic      factory_test,
  output int        aux_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_level = 1'b0;

  assign factory_test = 1'b0;
  // sampled on the falling edge so the count never races the driver
  always @(negedge core_clk) begin
    if (aux_clock_oe && aux_clock_out && !last_level) aux_edges++;
    last_level = aux_clock_out;
  end
endmodule // board_model

// *** test_reset_strap_aux_clock_out_ctrl.sv ***
/*
  Self-checking bench of the reset sequencer with strap capture.
  Assumes the design's default strap maps; power count shortened to 20.
*/
`include "reset_strap_defs.svh"

module test_reset_strap_aux_clock_out_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned P = 20;

  logic        core_clk, rst_n, por_active, lvr_active, ext_reset_n;
  logic        factory_test, sys_reset_n, aux_clock_out, aux_clock_oe;
  logic [1:0]  clk_strap, if_strap;
  logic [3:0]  pull_enable, drive_weak;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic        reg_wr, reg_rd;
  reset_strap_pkg::host_if_t     host_if_sel;
  reset_strap_pkg::aux_setting_t aux_setting;
  int          err_total, checks_done, cycles, aux_edges;
  bit          clk_run = 1'b1;
  logic [3:0]  aux_tbl [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  logic [3:0]  host_tbl [4] = '{4'h1, 4'h2, 4'h4, 4'h8};

  reset_strap_aux_clock_out_ctrl #(.POWER_RELEASE_TICKS(P)) dut (.core_clk, .rst_n,
    .por_active, .lvr_active, .ext_reset_n, .factory_test, .clk_strap,
    .if_strap, .sys_reset_n, .host_if_sel, .aux_setting, .aux_clock_out,
    .aux_clock_oe, .pull_enable, .drive_weak, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata);
  board_model board (.core_clk, .aux_clock_out, .aux_clock_oe,
    .factory_test, .aux_edges);

  // ------------------------------------------------------------------
  // clock, can be stopped to show that release needs it
  // ------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever begin
      #50;
      if (clk_run) core_clk = ~core_clk;
    end
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles > 5000) begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  task automatic wait_run(output int n);
    n = 0;
    while (sys_reset_n !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1 n++;
    end
  endtask

  // one reset from source src (0 power, 1 low voltage, 2 pin)
  task automatic reset_cycle(input int src, input logic [1:0] cs, is);
    logic [3:0] prev_aux;
    int n, e0;
    prev_aux = aux_setting;
    @(posedge core_clk);
    clk_strap <= 2'($urandom);
    if_strap <= 2'($urandom);
    if (src == 0) por_active <= 1'b1;
    else if (src == 1) lvr_active <= 1'b1;
    else ext_reset_n <= 1'b0;
    #1 chk("sys_reset_n", 0, sys_reset_n);
    e0 = aux_edges;
    repeat (6) @(posedge core_clk);
    #1;
    if (src < 2) begin
      chk("aux_off", 4'h1, aux_setting);
      chk("aux_oe", 0, aux_clock_oe);
    end else begin
      chk("aux_kept", prev_aux, aux_setting);
      chk("aux_running", prev_aux != 4'h1, aux_edges > e0);
    end
    // last strap value before release is the one that counts
    @(posedge core_clk);
    clk_strap <= cs;
    if_strap <= is;
    repeat (2) @(posedge core_clk);
    por_active <= 1'b0;
    lvr_active <= 1'b0;
    ext_reset_n <= 1'b1;
    wait_run(n);
    if (src < 2) chk("power_release", 1, n >= P && n <= P + 4);
    else chk("ext_release", 1, n >= 16 && n <= 22);
    chk("host_if_sel", host_tbl[is], host_if_sel);
    chk("aux_setting", aux_tbl[cs], aux_setting);
    e0 = aux_edges;
    @(posedge core_clk);
    clk_strap <= ~cs;
    if_strap <= ~is;
    repeat (19) @(posedge core_clk);
    #1;
    n = aux_edges - e0;
    chk("aux_edges", 1, cs == 0 ? n == 0 : n >= 9 && n <= 11);
    chk("host_frozen", host_tbl[is], host_if_sel);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] got, d;
    int n;
    void'($urandom(22606));
    {por_active, lvr_active, ext_reset_n, rst_n} = 4'b1010;
    {clk_strap, if_strap} = 4'b1001;
    {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    clk_run = 1'b0;
    #20 por_active = 1'b0;
    #3000 chk("no_clock_hold", 0, sys_reset_n);
    clk_run = 1'b1;
    wait_run(n);
    chk("first_host", host_tbl[1], host_if_sel);
    chk("first_aux", aux_tbl[2], aux_setting);
    chk("pull_enable", 0, pull_enable);
    chk("drive_weak", 0, drive_weak);
    rd(`REG_PAD_CTRL, got);
    chk("pad_reset", 0, got);
    d = $urandom;
    wr(`REG_PAD_CTRL, d);
    rd(`REG_PAD_CTRL, got);
    chk("pad_rw", d & 32'h0000_0F0F, got);
    chk("pull_port", d[3:0], pull_enable);
    chk("drive_port", d[11:8], drive_weak);
    rd(8'h40, got);
    chk("unmapped", 0, got);
    rd(`REG_STATUS, got);
    chk("status_run", 5'h10, got[4:0]);
    chk("status_aux", aux_tbl[2], got[11:8]);
    chk("status_host", host_tbl[1], got[15:12]);
    chk("status_straps", 4'h6, got[19:16]);
    chk("status_flags", 3'h1, got[22:20]);
    wr(`REG_STATUS, 32'h0070_0000);
    rd(`REG_STATUS, got);
    chk("flags_cleared", 0, got[22:20]);
    for (int i = 0; i < 4; i++) begin
      reset_cycle(i % 2, 2'(i), 2'(3 - i));
    end
    repeat (2) reset_cycle(2, 2'($urandom), 2'($urandom));
    chk("pad_after_reset", 0, pull_enable);
    rd(`REG_STATUS, got);
    chk("cause_flags", 3'h3, got[22:20]);
    finish_test();
  end
endmodule // test_reset_strap_aux_clock_out_ctrl
